// >>> hw/adc_regs_pkg.sv
/*
 * Shared constants and types of the converter register bank: selector
 * codes, reset values, configuration field layout, channel codes and the
 * conversion state encoding.
 * Assumes a single clock domain and a byte-level serial framer outside.
 */
`default_nettype none
package adc_regs_pkg;
	// Register selector codes (low two bits of the selector byte)
	localparam logic [1:0] SEL_RESULT = 2'h0;
	localparam logic [1:0] SEL_CONFIG = 2'h1;
	localparam logic [1:0] SEL_LOW    = 2'h2;
	localparam logic [1:0] SEL_HIGH   = 2'h3;
	localparam logic [1:0] SEL_RESET  = 2'h0;

	// Register values after reset
	localparam logic [15:0] RESULT_RESET = 16'h0000;
	localparam logic [15:0] CONFIG_RESET = 16'h8583;
	localparam logic [15:0] LOW_RESET    = 16'h8000;
	localparam logic [15:0] HIGH_RESET   = 16'h7FFF;

	// Configuration bit positions
	localparam int STATUS_BIT = 15;
	localparam int MODE_BIT   = 8;

	// Operating mode bit values
	localparam logic MODE_CONT   = 1'b0;
	localparam logic MODE_SINGLE = 1'b1;

	// Analog channel codes, ground as a fifth source
	localparam logic [2:0] CH_0   = 3'h0;
	localparam logic [2:0] CH_1   = 3'h1;
	localparam logic [2:0] CH_2   = 3'h2;
	localparam logic [2:0] CH_3   = 3'h3;
	localparam logic [2:0] CH_GND = 3'h4;

	// Byte position within a write transaction
	localparam logic [1:0] WR_PTR  = 2'h0;
	localparam logic [1:0] WR_MSB  = 2'h1;
	localparam logic [1:0] WR_LSB  = 2'h2;
	localparam logic [1:0] WR_DONE = 2'h3;

	// Configuration register layout, most significant field first
	typedef struct packed {
		logic       status;  // Status on read, start on write
		logic [2:0] pair;    // Input pair select
		logic [2:0] gain;    // Gain range select
		logic       mode;    // 0 continuous, 1 single-shot
		logic [2:0] rate;    // Sample rate select, 8 to 860 per second
		logic [4:0] comp;    // Comparator settings, stored only
	} config_t;

	// Positive and negative converter inputs
	typedef struct packed {
		logic [2:0] pos;
		logic [2:0] neg;
	} pair_t;

	// Conversion activity, Gray along idle, single, continuous
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_SINGLE = 2'b01,
		ST_CONT   = 2'b11
	} conv_state_t;
endpackage
`default_nettype wire

// >>> hw/adc_reg_bank.sv
/*
 * Register bank of a 16-bit converter: write-only selector, result,
 * configuration and two threshold registers, plus conversion start and
 * status tracking.
 * Assumes a serial framer delivering bytes and transaction starts, and an
 * analog core that takes a start pulse and returns a done pulse with data.
 */
// Functional notes
// - Four registers, chosen only by last selector
// - Selector 00 result, 01 config, 10/11 thresholds
// - Result is read-only signed 16-bit value
// - Result reads zero until first conversion ends
// - Configuration resets to 8583h
// - Start bit one launches conversion when idle
// - Start writes ignored while conversion runs
// - Status reads 0 busy, 1 idle
// - Bits 14:12 choose input pair, codes 4-7 single-ended to ground
// - Without multiplexer, always channel0 against channel1
// - Mode bit 0 continuous, 1 single-shot
// - Bits 7:5 select sample rate
`timescale 1ns/1ps
`default_nettype none
module adc_reg_bank
	import adc_regs_pkg::*;
#(
	parameter bit HAS_MUX = 1'b1  // Variant carries the input multiplexer
) (
	// Clock and synchronous active-low reset
	input  wire logic         CLOCK,
	input  wire logic         NRST,
	// Byte side of the serial framer
	input  wire logic         TXN_START,
	input  wire logic         WR_STB,
	input  wire logic [7:0]   WR_BYTE,
	input  wire logic         RD_STB,
	output var  logic [7:0]   RD_BYTE,
	output var  logic         RD_VALID,
	// Analog core side
	input  wire logic         CONV_DONE,
	input  wire logic [15:0]  CONV_DATA,
	output var  logic         CONV_START,
	output var  logic         CONV_BUSY,
	output var  pair_t        PAIR,
	output var  config_t      CONFIG
);

	// Maps the select code to the converter inputs
	function automatic pair_t decode_pair(input logic [2:0] code);
		pair_t p;
		p = '{pos: CH_0, neg: CH_1};
		if (HAS_MUX) begin
			case (code)
				3'h0: p = '{pos: CH_0, neg: CH_1};
				3'h1: p = '{pos: CH_0, neg: CH_3};
				3'h2: p = '{pos: CH_1, neg: CH_3};
				3'h3: p = '{pos: CH_2, neg: CH_3};
				default: p = '{pos: code - 3'h4, neg: CH_GND};
			endcase
		end
		return p;
	endfunction

	// Register state
	logic [1:0]  sel_q, sel_d;        // Register selector
	logic [1:0]  wcnt_q, wcnt_d;      // Byte position in write
	logic [7:0]  msb_q, msb_d;        // Held high byte of a write
	logic [15:0] result_q, result_d;  // Conversion result
	config_t     cfg_q, cfg_d;        // Configuration
	logic [15:0] low_q, low_d;        // Low threshold
	logic [15:0] high_q, high_d;      // High threshold
	conv_state_t state_q, state_d;    // Conversion activity
	logic        start_q, start_d;    // Start pulse to core
	logic        busy_q, busy_d;      // Busy mirror
	pair_t       pair_q, pair_d;      // Decoded input pair
	logic [15:0] word;                // Word completed by a write
	config_t     wcfg;                // Same word seen as configuration

	// Next values of the register file and conversion control
	always_comb begin
		sel_d    = sel_q;
		wcnt_d   = wcnt_q;
		msb_d    = msb_q;
		result_d = result_q;
		cfg_d    = cfg_q;
		low_d    = low_q;
		high_d   = high_q;
		state_d  = state_q;
		start_d  = 1'b0;
		word     = {msb_q, WR_BYTE};
		wcfg     = config_t'(word);
		// Finished conversion loads the result
		if (CONV_DONE) begin
			result_d = CONV_DATA;
			if (state_q == ST_SINGLE) begin
				state_d = ST_IDLE;
			end
		end
		// Write transaction bytes: selector, high, low
		if (TXN_START) begin
			wcnt_d = WR_PTR;
		end else if (WR_STB) begin
			case (wcnt_q)
				WR_PTR: begin
					sel_d  = WR_BYTE[1:0];
					wcnt_d = WR_MSB;
				end
				WR_MSB: begin
					msb_d  = WR_BYTE;
					wcnt_d = WR_LSB;
				end
				WR_LSB: begin
					wcnt_d = WR_DONE;
					case (sel_q)
						SEL_CONFIG: begin
							cfg_d        = wcfg;
							cfg_d.status = 1'b0;
							// Start only from power-down
							if (state_d == ST_IDLE) begin
								if (wcfg.mode == MODE_CONT) begin
									state_d = ST_CONT;
									start_d = 1'b1;
								end else if (wcfg.status) begin
									state_d = ST_SINGLE;
									start_d = 1'b1;
								end
							end else if (state_d == ST_CONT && wcfg.mode == MODE_SINGLE) begin
								// Current conversion finishes, then power-down
								state_d = ST_SINGLE;
							end
						end
						SEL_LOW:  low_d  = word;
						SEL_HIGH: high_d = word;
						default: ;  // Result is read-only
					endcase
				end
				default: ;  // Surplus bytes are dropped
			endcase
		end
		busy_d = (state_d != ST_IDLE);
		pair_d = decode_pair(cfg_d.pair);
	end

	// Register file and control flip-flops
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			sel_q    <= SEL_RESET;
			wcnt_q   <= WR_PTR;
			msb_q    <= 8'h00;
			result_q <= RESULT_RESET;
			cfg_q    <= config_t'(CONFIG_RESET & 16'h7FFF);
			low_q    <= LOW_RESET;
			high_q   <= HIGH_RESET;
			state_q  <= ST_IDLE;
			start_q  <= 1'b0;
			busy_q   <= 1'b0;
			pair_q   <= '{pos: CH_0, neg: CH_1};
		end else begin
			sel_q    <= sel_d;
			wcnt_q   <= wcnt_d;
			msb_q    <= msb_d;
			result_q <= result_d;
			cfg_q    <= cfg_d;
			low_q    <= low_d;
			high_q   <= high_d;
			state_q  <= state_d;
			start_q  <= start_d;
			busy_q   <= busy_d;
			pair_q   <= pair_d;
		end
	end

	// Read path state
	logic [7:0]  rd_byte_q, rd_byte_d;  // Byte handed to the framer
	logic        rd_valid_q, rd_valid_d;  // Byte valid strobe
	logic        rd_lo_q, rd_lo_d;      // Next byte is the low byte
	logic [15:0] rword;                 // Selected register contents

	// Next read byte, high byte first
	always_comb begin
		rd_byte_d  = rd_byte_q;
		rd_valid_d = 1'b0;
		rd_lo_d    = rd_lo_q;
		case (sel_q)
			SEL_RESULT: rword = result_q;
			SEL_CONFIG: rword = {(state_q == ST_IDLE), cfg_q[14:0]};
			SEL_LOW:    rword = low_q;
			default:    rword = high_q;
		endcase
		if (TXN_START) begin
			rd_lo_d = 1'b0;
		end else if (RD_STB) begin
			rd_byte_d  = rd_lo_q ? rword[7:0] : rword[15:8];
			rd_valid_d = 1'b1;
			rd_lo_d    = ~rd_lo_q;
		end
	end

	// Read path flip-flops
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			rd_byte_q  <= 8'h00;
			rd_valid_q <= 1'b0;
			rd_lo_q    <= 1'b0;
		end else begin
			rd_byte_q  <= rd_byte_d;
			rd_valid_q <= rd_valid_d;
			rd_lo_q    <= rd_lo_d;
		end
	end

	// Outputs straight from flip-flops
	assign RD_BYTE    = rd_byte_q;
	assign RD_VALID   = rd_valid_q;
	assign CONV_START = start_q;
	assign CONV_BUSY  = busy_q;
	assign PAIR       = pair_q;
	assign CONFIG     = cfg_q;

	// Checks
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!NRST);

	sequence ptr_byte;
		WR_STB && !TXN_START && wcnt_q == WR_PTR;
	endsequence
	sequence cfg_start_idle;
		WR_STB && !TXN_START && wcnt_q == WR_LSB && sel_q == SEL_CONFIG
			&& state_q == ST_IDLE && !CONV_DONE && msb_q[7];
	endsequence

	a_ptr_select: assert property (
		ptr_byte |=> sel_q == $past(WR_BYTE[1:0])) else $error("selector not loaded");
	a_sel_hold: assert property (
		!(WR_STB && !TXN_START && wcnt_q == WR_PTR) |=> $stable(sel_q))
		else $error("selector changed without write");
	a_result_load: assert property (
		CONV_DONE |=> result_q == $past(CONV_DATA)) else $error("result not loaded");
	a_result_hold: assert property (
		!CONV_DONE |=> $stable(result_q)) else $error("result changed without conversion");
	a_cfg_reset: assert property (
		disable iff (1'b0) !NRST |=> cfg_q[14:0] == CONFIG_RESET[14:0] && state_q == ST_IDLE)
		else $error("configuration reset wrong");
	a_start_pulse: assert property (
		cfg_start_idle |=> CONV_START && CONV_BUSY ##1 !CONV_START) else $error("start missing");
	a_start_idle_only: assert property (
		CONV_START |-> $past(state_q) == ST_IDLE
			|| ($past(state_q) == ST_SINGLE && $past(CONV_DONE)))
		else $error("start while converting");
	a_status_read: assert property (
		RD_STB && !TXN_START && !rd_lo_q && sel_q == SEL_CONFIG
			|=> RD_VALID && RD_BYTE[7] == $past(state_q == ST_IDLE)) else $error("status bit wrong");
	a_fixed_pair: assert property (
		!HAS_MUX |-> PAIR == pair_t'{pos: CH_0, neg: CH_1}) else $error("pair not fixed");
	a_ground_pair: assert property (
		HAS_MUX && cfg_q.pair[2] |-> PAIR.neg == CH_GND) else $error("single-ended pair wrong");
	a_msb_first: assert property (
		RD_STB && !TXN_START && !rd_lo_q && sel_q == SEL_RESULT && !CONV_DONE
			|=> RD_BYTE == $past(result_q[15:8])) else $error("high byte not first");
	a_cont_mode: assert property (
		state_q == ST_CONT |-> cfg_q.mode == MODE_CONT && CONV_BUSY) else $error("mode mismatch");

endmodule
`default_nettype wire

// >>> sim/adc_core_model.sv
/*
 * Stand-in for the analog core: answers each start with a done pulse.
 * Assumes the bench supplies the latency and the data to return.
 */
`timescale 1ns/1ps
`default_nettype none
module adc_core_model (
	// Clock and converter handshake
	input  wire logic        CLOCK,
	input  wire logic        CONV_START,
	input  wire logic        CONV_BUSY,
	// Bench controls
	input  wire logic [7:0]  lat,
	input  wire logic [15:0] data_in,
	// Answer to the register bank
	output var  logic        CONV_DONE,
	output var  logic [15:0] CONV_DATA
);
	// Converts once per start, again while continuous mode holds busy
	initial begin
		CONV_DONE = 1'b0;
		CONV_DATA = 16'hFFFF;
		forever begin
			@(posedge CLOCK);
			if (CONV_START === 1'b1) begin
				do begin
					repeat (lat) @(negedge CLOCK);
					CONV_DONE <= 1'b1;
					CONV_DATA <= data_in;
					@(negedge CLOCK);
					CONV_DONE <= 1'b0;
					CONV_DATA <= ~data_in;  // Data is not held after done
					repeat (2) @(negedge CLOCK);
				end while (CONV_BUSY === 1'b1);
			end
		end
	end
endmodule
`default_nettype wire

// >>> sim/adc_reg_bank_tb.sv
/*
 * Self-checking bench of the converter register bank.
 * Assumes the core model answers starts; inputs change at falling edges.
 */
`timescale 1ns/1ps
`default_nettype none
module adc_reg_bank_tb;
	import adc_regs_pkg::*;
	logic        CLOCK, NRST, TXN_START, WR_STB, RD_STB, CONV_DONE, st;
	logic [7:0]  WR_BYTE, RD_BYTE, lat;
	logic        RD_VALID, CONV_START, CONV_BUSY;
	logic [15:0] CONV_DATA, d_in, v, cfg, lo, hi, res;
	logic        busy;  // Expected conversion activity
	pair_t       PAIR;
	config_t     CONFIG;
	int          bad_count, n_tests;
	adc_reg_bank DUT (.CLOCK(CLOCK), .NRST(NRST), .TXN_START(TXN_START),
		.WR_STB(WR_STB), .WR_BYTE(WR_BYTE), .RD_STB(RD_STB), .RD_BYTE(RD_BYTE),
		.RD_VALID(RD_VALID), .CONV_DONE(CONV_DONE), .CONV_DATA(CONV_DATA),
		.CONV_START(CONV_START), .CONV_BUSY(CONV_BUSY), .PAIR(PAIR), .CONFIG(CONFIG));
	adc_core_model CORE (.CLOCK(CLOCK), .CONV_START(CONV_START), .CONV_BUSY(CONV_BUSY),
		.lat(lat), .data_in(d_in), .CONV_DONE(CONV_DONE), .CONV_DATA(CONV_DATA));
	// 200 MHz clock
	initial begin
		CLOCK = 1'b0;
		forever #2.5 CLOCK = ~CLOCK;
	end
	// Prints the verdict and ends the run
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Compares one result
	task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Write transaction: selector, then optionally high and low bytes
	task automatic wr(input logic [1:0] sel, input logic [15:0] d, input bit full);
		TXN_START = 1'b1;
		@(negedge CLOCK);
		TXN_START = 1'b0;
		WR_STB = 1'b1;
		WR_BYTE = {6'h00, sel};
		if (full) begin
			@(negedge CLOCK);
			WR_BYTE = d[15:8];
			@(negedge CLOCK);
			WR_BYTE = d[7:0];
			if (sel == 2'h1) cfg = d;
			if (sel == 2'h2) lo = d;
			if (sel == 2'h3) hi = d;
		end
		@(negedge CLOCK);
		WR_STB = 1'b0;
		st = CONV_START;
		if (full && sel == 2'h1) cmp("config", {1'b0, d[14:0]}, CONFIG);
	endtask
	// Selects a register, reads it high byte first, compares with the model
	task automatic chk(input logic [1:0] sel);
		logic [15:0] e;
		wr(sel, 16'h0000, 1'b0);
		TXN_START = 1'b1;
		@(negedge CLOCK);
		TXN_START = 1'b0;
		RD_STB = 1'b1;
		for (int i = 0; i < 2; i++) begin
			@(negedge CLOCK);
			RD_STB = (i == 0);
			cmp("rd_valid", 16'h0001, {15'h0000, RD_VALID});
			v = {v[7:0], RD_BYTE};
		end
		e = (sel == 2'h0) ? res : (sel == 2'h1) ? {~busy, cfg[14:0]} : (sel == 2'h2) ? lo : hi;
		cmp("register", e, v);
	endtask
	// Waits for the core to finish, then checks busy afterwards
	task automatic wait_done(input logic single);
		int i;
		i = 0;
		do begin
			@(posedge CLOCK);
			i++;
		end while (CONV_DONE !== 1'b1 && i < 300);
		if (i >= 300) bad_count++;
		res = CONV_DATA;
		busy = ~single;
		@(negedge CLOCK);
		cmp("busy", {15'h0000, busy}, {15'h0000, CONV_BUSY});
	endtask
	// Watchdog against a hang
	initial begin
		#200000;
		bad_count++;
		conclude();
	end
	// Main sequence
	initial begin
		{NRST, TXN_START, WR_STB, RD_STB, WR_BYTE, lat, d_in, v} = '0;
		{cfg, lo, hi, res, busy} = {16'h8583, 16'h8000, 16'h7FFF, 16'h0000, 1'b0};
		bad_count = 0;
		n_tests = 0;
		void'($urandom(75));
		repeat (4) @(negedge CLOCK);
		NRST = 1'b1;
		for (int s = 0; s < 4; s++) chk(2'(s));
		for (int s = 2; s < 4; s++) begin
			wr(2'(s), 16'($urandom), 1'b1);
			chk(2'(s));
		end
		wr(2'h0, 16'($urandom), 1'b1);
		chk(2'h0);
		for (int c = 0; c < 8; c++) begin
			lat = 8'(16 + 4 * c);
			d_in = 16'($urandom);
			wr(2'h1, {1'b1, 3'(c), 12'($urandom) | 12'h100}, 1'b1);
			busy = 1'b1;
			cmp("start", 16'h0001, {15'h0000, st});
			cmp("pair", (c < 4) ? {10'h000, (c < 2) ? 3'h0 : 3'(c - 1), (c == 0) ? 3'h1 : 3'h3}
				: {10'h000, 3'(c - 4), 3'h4}, {10'h000, PAIR});
			chk(2'h1);
			wr(2'h1, cfg, 1'b1);
			cmp("restart", 16'h0000, {15'h0000, st});
			wait_done(1'b1);
			chk(2'h0);
			chk(2'h1);
		end
		wr(2'h1, 16'h0583, 1'b1);
		cmp("start_zero", 16'h0000, {15'h0000, st});
		lat = 8'd30;
		wr(2'h1, 16'h0483, 1'b1);
		busy = 1'b1;
		cmp("cont_start", 16'h0001, {15'h0000, st});
		wait_done(1'b0);
		wr(2'h1, 16'h0583, 1'b1);
		wait_done(1'b1);
		chk(2'h0);
		chk(2'h1);
		conclude();
	end
endmodule
`default_nettype wire
